//--- rtl/vfd_pkg.sv
/*
  vfd_pkg: constants of the field-encoding decoder, namely the encoding bit
  positions, group codes, storage slot bases, register offsets and reset values.
  Assumes: imported by vfd_decode, vfd_top, vfd_checker and tb.
*/
package vfd_pkg;

  // ------------------------------------------------------------
  // encoding layout
  // ------------------------------------------------------------
  localparam int ENC_WIDTH_HI = 14;
  localparam int ENC_WIDTH_LO = 13;
  localparam int ENC_RSVD_BIT = 12;
  localparam int ENC_TYPE_HI = 11;
  localparam int ENC_TYPE_LO = 10;
  localparam int ENC_INDEX_HI = 9;
  localparam int ENC_INDEX_LO = 1;
  localparam int ENC_ACCESS_BIT = 0;
  localparam int ENC_UPPER_LO = 15;

  localparam logic [1:0] WIDTH_32 = 2'h2;
  localparam logic [1:0] WIDTH_NATURAL = 2'h3;
  localparam logic [1:0] TYPE_CONTROL = 2'h0;
  localparam logic [1:0] TYPE_READ_ONLY = 2'h1;
  localparam logic [1:0] TYPE_GUEST = 2'h2;
  localparam logic [1:0] TYPE_HOST = 2'h3;

  // ------------------------------------------------------------
  // group sizes and notable encodings
  // ------------------------------------------------------------
  localparam logic [8:0] G32_LAST_PLAIN = 9'h015;
  localparam logic [8:0] G32_UNASSIGNED = 9'h016;
  localparam logic [31:0] ENC_PREEMPT_TIMER = 32'h0000482e;
  localparam logic [31:0] ENC_HOST_SYS_ENTRY_SEL = 32'h00004c00;
  localparam logic [8:0] NCTL_FIXED = 9'h004;
  localparam logic [8:0] CR3_TARGETS = 9'h004;
  localparam logic [8:0] NRO_COUNT = 9'h006;
  localparam logic [8:0] NGST_COUNT = 9'h014;

  // ------------------------------------------------------------
  // storage slots
  // ------------------------------------------------------------
  localparam int FIELD_COUNT = 59;
  localparam logic [5:0] BASE_G32 = 6'h00;
  localparam logic [5:0] BASE_H32 = 6'h18;
  localparam logic [5:0] BASE_NCTL = 6'h19;
  localparam logic [5:0] BASE_NRO = 6'h21;
  localparam logic [5:0] BASE_NGST = 6'h27;
  localparam int SLOT_GDT_LIMIT = 8;
  localparam int SLOT_IDT_LIMIT = 9;
  localparam int SLOT_SEG_BASE_FIRST = 42;
  localparam int SLOT_SEG_BASE_LAST = 45;
  localparam logic [63:0] KEEP_LOW16 = 64'h0000_0000_0000_ffff;
  localparam logic [63:0] KEEP_LOW32 = 64'h0000_0000_ffff_ffff;
  localparam logic [63:0] KEEP_ALL = 64'hffff_ffff_ffff_ffff;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_ENCODING = 8'h00;
  localparam logic [7:0] OFS_WDATA_LO = 8'h04;
  localparam logic [7:0] OFS_WDATA_HI = 8'h08;
  localparam logic [7:0] OFS_COMMAND = 8'h0c;
  localparam logic [7:0] OFS_DECODE = 8'h10;
  localparam logic [7:0] OFS_RDATA_LO = 8'h14;
  localparam logic [7:0] OFS_RDATA_HI = 8'h18;
  localparam logic [7:0] OFS_CONFIG = 8'h1c;

  localparam int CMD_READ = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_ENTRY = 2;
  localparam int CMD_CLR_FAIL = 3;
  localparam int CFG_TIMER = 0;

  localparam logic [31:0] RST_ENCODING = 32'h0000_0000;
  localparam logic [31:0] RST_WDATA = 32'h0000_0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  localparam logic RST_CONFIG_TIMER = 1'b0;

endpackage : vfd_pkg

//--- rtl/vfd_decode.sv
/*
  vfd_decode: combinational decode of one field encoding into width, type,
  index, storage slot and a supported flag.
  Assumes: encoding held stable by the caller; timer support from config.
*/
`timescale 1ns/100ps
`default_nettype none
module vfd_decode
  import vfd_pkg::*;
(
  input wire logic [31:0] enc,
  input wire logic timer_supported,
  output logic [1:0] width,
  output logic [1:0] ftype,
  output logic [8:0] index,
  output logic supported,
  output logic read_only,
  output logic [5:0] slot
);

  // ------------------------------------------------------------
  // group match
  // ------------------------------------------------------------
  function automatic logic in_group(input logic [31:0] e, input logic [1:0] w,
                                    input logic [1:0] t);
    in_group = (e[ENC_WIDTH_HI:ENC_WIDTH_LO] == w) && (e[ENC_TYPE_HI:ENC_TYPE_LO] == t);
  endfunction : in_group

  wire logic shape_ok;
  wire logic grp_g32;
  wire logic grp_h32;
  wire logic grp_nctl;
  wire logic grp_nro;
  wire logic grp_ngst;
  wire logic ok_g32;
  wire logic ok_timer;
  wire logic ok_h32;
  wire logic ok_nctl;
  wire logic ok_nro;
  wire logic ok_ngst;
  wire logic [5:0] base;

  assign width = enc[ENC_WIDTH_HI:ENC_WIDTH_LO];
  assign ftype = enc[ENC_TYPE_HI:ENC_TYPE_LO];
  assign index = enc[ENC_INDEX_HI:ENC_INDEX_LO];

  // full access only: odd encodings never select storage
  assign shape_ok = (enc[31:ENC_UPPER_LO] == 17'h00000) && !enc[ENC_RSVD_BIT]
                    && !enc[ENC_ACCESS_BIT];

  assign grp_g32 = in_group(enc, WIDTH_32, TYPE_GUEST);
  assign grp_h32 = in_group(enc, WIDTH_32, TYPE_HOST);
  assign grp_nctl = in_group(enc, WIDTH_NATURAL, TYPE_CONTROL);
  assign grp_nro = in_group(enc, WIDTH_NATURAL, TYPE_READ_ONLY);
  assign grp_ngst = in_group(enc, WIDTH_NATURAL, TYPE_GUEST);

  // ------------------------------------------------------------
  // per-group index ranges
  // ------------------------------------------------------------
  assign ok_g32 = grp_g32 && (index <= G32_LAST_PLAIN);
  assign ok_timer = (enc == ENC_PREEMPT_TIMER) && timer_supported;
  assign ok_h32 = (enc == ENC_HOST_SYS_ENTRY_SEL);
  assign ok_nctl = grp_nctl && (index < NCTL_FIXED + CR3_TARGETS);
  assign ok_nro = grp_nro && (index < NRO_COUNT);
  assign ok_ngst = grp_ngst && (index < NGST_COUNT);

  assign supported = shape_ok && (ok_g32 || ok_timer || ok_h32 || ok_nctl || ok_nro
                                  || ok_ngst);
  assign read_only = grp_nro;

  assign base = grp_h32 ? BASE_H32 :
                grp_nctl ? BASE_NCTL :
                grp_nro ? BASE_NRO :
                grp_ngst ? BASE_NGST : BASE_G32;
  assign slot = supported ? 6'(base + index[5:0]) : 6'h00;

endmodule : vfd_decode
`default_nettype wire

//--- rtl/vfd_top.sv
/*
  vfd_top: field store reached through encodings, with APB register access,
  field read and write commands and the clearing done on machine entry.
  Assumes: APB3 master on pclk; entry_event is a one-cycle pulse on pclk.
*/
// The implementer's own choices: the APB register port and the register offsets.
// Function
// - width bits 14:13 equal to 3 mark a natural-width field.
// - width bits 14:13 equal to 2 mark a 32-bit field.
// - type bits 11:10 select control, read-only, guest-state or host-state.
// - within one width and type group only index bits 9:1 tell fields apart.
// - these fields are full access only, so valid encodings are even.
// - the only 32-bit host field is the entry code selector at 00004c00.
// - descriptor table limits are stored 32 bits and entry clears their top 16 bits.
// - guest ES, CS, SS and DS bases are natural width and entry clears their top 32 bits.
// - extra page-table-base target values follow the four defined encodings.
// - the preemption timer field at 0000482e decodes only when the timer is supported.
// - guest limits sit at 00004800 to 00004812 and access rights from 00004814.
// - interruptibility, activity, mgmt base and entry selector sit at 00004824 to 0000482a.
// - natural control masks, shadows and target values start at 00006000.
// - natural read-only fields run from 00006400 to 0000640a.
// - natural guest control registers and segment bases start at 00006800.
// - guest debug control through the entry instruction pointer end at 00006826.
`timescale 1ns/100ps
`default_nettype none
module vfd_top
  import vfd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vfd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic entry_event,
  output logic field_unsupported
);

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  logic [31:0] encoding;
  logic [31:0] wdata_lo;
  logic [31:0] wdata_hi;
  logic [31:0] rdata_lo;
  logic [31:0] rdata_hi;
  logic timer_supported;
  logic op_failed;
  logic [31:0] prdata_q;
  logic [63:0] field_q [FIELD_COUNT];

  // ------------------------------------------------------------
  // decode of the current encoding
  // ------------------------------------------------------------
  logic [1:0] dec_width;
  logic [1:0] dec_type;
  logic [8:0] dec_index;
  logic dec_supported;
  logic dec_read_only;
  logic [5:0] dec_slot;

  vfd_decode u_decode (
    .enc(encoding),
    .timer_supported(timer_supported),
    .width(dec_width),
    .ftype(dec_type),
    .index(dec_index),
    .supported(dec_supported),
    .read_only(dec_read_only),
    .slot(dec_slot)
  );

  // ------------------------------------------------------------
  // bus phases and address decode
  // ------------------------------------------------------------
  wire logic setup_phase;
  wire logic access_wr;
  wire logic hit_encoding;
  wire logic hit_wdata_lo;
  wire logic hit_wdata_hi;
  wire logic hit_command;
  wire logic hit_decode;
  wire logic hit_rdata_lo;
  wire logic hit_rdata_hi;
  wire logic hit_config;
  wire logic mapped;

  assign setup_phase = ce && psel && !penable;
  assign access_wr = ce && psel && penable && pwrite && mapped;

  assign hit_encoding = (paddr == OFS_ENCODING);
  assign hit_wdata_lo = (paddr == OFS_WDATA_LO);
  assign hit_wdata_hi = (paddr == OFS_WDATA_HI);
  assign hit_command = (paddr == OFS_COMMAND);
  assign hit_decode = (paddr == OFS_DECODE);
  assign hit_rdata_lo = (paddr == OFS_RDATA_LO);
  assign hit_rdata_hi = (paddr == OFS_RDATA_HI);
  assign hit_config = (paddr == OFS_CONFIG);
  assign mapped = hit_encoding || hit_wdata_lo || hit_wdata_hi || hit_command
                  || hit_decode || hit_rdata_lo || hit_rdata_hi || hit_config;

  // zero wait states; frozen clock enable stalls the transfer
  assign pready = ce;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  // ------------------------------------------------------------
  // commands
  // ------------------------------------------------------------
  wire logic cmd_write_hit;
  wire logic cmd_read;
  wire logic cmd_write;
  wire logic cmd_clr_fail;
  wire logic do_entry;
  wire logic store_write;
  wire logic fail_set;
  wire logic [63:0] store_data;
  wire logic [63:0] read_value;

  assign cmd_write_hit = access_wr && hit_command;
  assign cmd_read = cmd_write_hit && pwdata[CMD_READ];
  assign cmd_write = cmd_write_hit && pwdata[CMD_WRITE];
  assign cmd_clr_fail = cmd_write_hit && pwdata[CMD_CLR_FAIL];
  assign do_entry = ce && ((cmd_write_hit && pwdata[CMD_ENTRY]) || entry_event);

  // unsupported encodings and read-only fields never reach storage
  assign store_write = cmd_write && dec_supported && !dec_read_only;
  assign fail_set = (cmd_read && !dec_supported)
                    || (cmd_write && (!dec_supported || dec_read_only));

  // 32-bit fields keep only their low word
  assign store_data = (dec_width == WIDTH_32) ? {32'h0000_0000, wdata_lo}
                                              : {wdata_hi, wdata_lo};
  assign read_value = dec_supported ? field_q[dec_slot] : 64'h0;

  // ------------------------------------------------------------
  // field store with entry clearing
  // ------------------------------------------------------------
  function automatic logic [63:0] entry_keep(input int slot_n);
    if (slot_n == SLOT_GDT_LIMIT || slot_n == SLOT_IDT_LIMIT) begin
      entry_keep = KEEP_LOW16;
    end else if (slot_n >= SLOT_SEG_BASE_FIRST && slot_n <= SLOT_SEG_BASE_LAST) begin
      entry_keep = KEEP_LOW32;
    end else begin
      entry_keep = KEEP_ALL;
    end
  endfunction : entry_keep

  genvar gi;
  generate
    for (gi = 0; gi < FIELD_COUNT; gi++) begin : g_field
      wire logic wr_hit;
      wire logic [63:0] written;
      wire logic [63:0] next_field;

      assign wr_hit = store_write && (dec_slot == 6'(gi));
      assign written = wr_hit ? store_data : field_q[gi];
      // entry clearing applies after a write in the same cycle
      assign next_field = do_entry ? (written & entry_keep(gi)) : written;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          field_q[gi] <= 64'h0;
        end else if (ce) begin
          field_q[gi] <= next_field;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // software register writes
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      encoding <= RST_ENCODING;
      wdata_lo <= RST_WDATA;
      wdata_hi <= RST_WDATA;
      timer_supported <= RST_CONFIG_TIMER;
    end else if (access_wr) begin
      if (hit_encoding) begin
        encoding <= pwdata;
      end
      if (hit_wdata_lo) begin
        wdata_lo <= pwdata;
      end
      if (hit_wdata_hi) begin
        wdata_hi <= pwdata;
      end
      if (hit_config) begin
        timer_supported <= pwdata[CFG_TIMER];
      end
    end
  end

  // ------------------------------------------------------------
  // field read results and failure flag
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_lo <= RST_RDATA;
      rdata_hi <= RST_RDATA;
    end else if (cmd_read) begin
      rdata_lo <= read_value[31:0];
      rdata_hi <= read_value[63:32];
    end
  end

  // a new failure wins over a clear in the same write
  wire logic next_op_failed;
  assign next_op_failed = fail_set ? 1'b1 : (cmd_clr_fail ? 1'b0 : op_failed);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_failed <= 1'b0;
    end else if (ce) begin
      op_failed <= next_op_failed;
    end
  end

  // ------------------------------------------------------------
  // read data, captured in the setup cycle
  // ------------------------------------------------------------
  wire logic [31:0] decode_word;
  wire logic [31:0] read_mux;

  assign decode_word = {11'h000, op_failed, dec_slot, dec_supported, dec_index,
                        dec_type, dec_width};
  assign read_mux = hit_encoding ? encoding :
                    hit_wdata_lo ? wdata_lo :
                    hit_wdata_hi ? wdata_hi :
                    hit_decode ? decode_word :
                    hit_rdata_lo ? rdata_lo :
                    hit_rdata_hi ? rdata_hi :
                    hit_config ? {31'h0000_0000, timer_supported} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata_q <= pwrite ? 32'h0000_0000 : read_mux;
    end
  end

  // ------------------------------------------------------------
  // status pin
  // ------------------------------------------------------------
  logic unsupported_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unsupported_q <= 1'b1;
    end else if (ce) begin
      unsupported_q <= !dec_supported;
    end
  end

  assign field_unsupported = unsupported_q;

endmodule : vfd_top
`default_nettype wire

//--- tb/vfd_checker.sv
/*
  vfd_checker: concurrent checks on the ports of vfd_top.
  Assumes: bound to vfd_top from the bench; single pclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module vfd_checker
  import vfd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vfd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic entry_event,
  input wire logic field_unsupported
);
  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc_wr = psel && penable && pready && pwrite;
  wire logic cause_wr = acc_wr && (paddr == OFS_ENCODING || paddr == OFS_CONFIG);
  sequence enc_written;
    acc_wr && paddr == OFS_ENCODING;
  endsequence
  sequence enc_settled(cond);
    enc_written ##0 cond ##1 ce;
  endsequence
  property enc_when(cond, logic exp);
    enc_settled(cond) |=> field_unsupported == exp;
  endproperty
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  odd_enc_flag_a: assert property (enc_when(pwdata[0], 1'b1))
    else $error("odd encoding not flagged");
  bad_width_a: assert property (enc_when(pwdata[14] == 1'b0, 1'b1))
    else $error("encoding of other width not flagged");
  host_sel_ok_a: assert property (enc_when(pwdata == 32'h0000_4c00, 1'b0))
    else $error("host selector refused");
  host_other_a: assert property (enc_when(pwdata == 32'h0000_4c02, 1'b1))
    else $error("second host field accepted");
  idx_gap_a: assert property (enc_when(pwdata == 32'h0000_482c, 1'b1))
    else $error("unassigned index accepted");
  rights_ok_a: assert property (enc_when(pwdata == 32'h0000_4814, 1'b0))
    else $error("access rights refused");
  target_end_a: assert property (enc_when(pwdata == 32'h0000_6010, 1'b1))
    else $error("fifth target value accepted");
  linear_ok_a: assert property (enc_when(pwdata == 32'h0000_640a, 1'b0))
    else $error("linear address refused");
  seg_base_ok_a: assert property (enc_when(pwdata == 32'h0000_6806, 1'b0))
    else $error("segment base refused");
  guest_end_a: assert property (enc_when(pwdata == 32'h0000_6828, 1'b1))
    else $error("field past guest group accepted");
  flag_cause_a: assert property ($changed(field_unsupported) |-> $past(cause_wr, 2))
    else $error("flag moved without cause");
endmodule : vfd_checker
`default_nettype wire

//--- tb/vfd_tb.sv
/*
  vfd_tb: self-checking bench for vfd_top over APB.
  Assumes: vfd_pkg compiled first; checker bound below.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import vfd_pkg::*;
  localparam logic [63:0] NAT = 64'h1234_5678_9abc_def0;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic ce = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic entry_event = 1'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic field_unsupported;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic [63:0] fv;
  logic er;
  always #2 pclk = ~pclk;
  vfd_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .entry_event(entry_event), .field_unsupported(field_unsupported));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic fwrite(input logic [31:0] e, input logic [63:0] v);
    apb(1'h1, OFS_ENCODING, e);
    apb(1'h1, OFS_WDATA_LO, v[31:0]);
    apb(1'h1, OFS_WDATA_HI, v[63:32]);
    apb(1'h1, OFS_COMMAND, 32'h1 << CMD_WRITE);
  endtask : fwrite
  task automatic fread(input logic [31:0] e);
    apb(1'h1, OFS_ENCODING, e);
    apb(1'h1, OFS_COMMAND, 32'h1 << CMD_READ);
    apb(1'h0, OFS_RDATA_LO, 32'h0);
    fv[31:0] = rd;
    apb(1'h0, OFS_RDATA_HI, 32'h0);
    fv[63:32] = rd;
  endtask : fread
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    apb(1'h0, OFS_ENCODING, 32'h0);
    chk(rd, RST_ENCODING, "encoding reset");
    apb(1'h0, OFS_DECODE, 32'h0);
    chk({rd[13], field_unsupported}, 2'h1, "zero encoding");
    apb(1'h0, OFS_COMMAND, 32'h0);
    chk(rd, 32'h0, "command reads zero");
    apb(1'h1, 8'h20, 32'hffff_ffff);
    chk(er, 1'h1, "unmapped write");
    apb(1'h0, 8'h20, 32'h0);
    chk({er, rd}, {1'h1, 32'h0}, "unmapped read");
    $display("test regs done");
  endtask : t_regs
  task automatic t_decode();
    logic [31:0] good [18] = '{32'h4800, 32'h4812, 32'h4814, 32'h4822, 32'h4824, 32'h482a,
      32'h4c00, 32'h6000, 32'h6006, 32'h6008, 32'h600e, 32'h6400, 32'h640a, 32'h6800,
      32'h6806, 32'h6818, 32'h681a, 32'h6826};
    logic [31:0] bad [12] = '{32'h0, 32'h4801, 32'h482c, 32'h482e, 32'h4c02, 32'h6010,
      32'h640c, 32'h6828, 32'h6c00, 32'h2800, 32'h1_4800, 32'h5800};
    logic [5:0] base;
    foreach (good[i]) begin
      apb(1'h1, OFS_ENCODING, good[i]);
      apb(1'h0, OFS_DECODE, 32'h0);
      base = good[i][13] ? (good[i][11] ? BASE_NGST : (good[i][10] ? BASE_NRO : BASE_NCTL))
        : (good[i][11:10] == TYPE_HOST ? BASE_H32 : BASE_G32);
      chk(rd[19:0], {base + 6'(good[i][9:1]), 1'h1, good[i][9:1], good[i][11:10],
        good[i][14:13]}, "decode fields");
      chk(field_unsupported, 1'h0, "good flagged");
    end
    foreach (bad[i]) begin
      apb(1'h1, OFS_ENCODING, bad[i]);
      apb(1'h0, OFS_DECODE, 32'h0);
      chk({rd[13], field_unsupported}, 2'h1, "bad accepted");
    end
    apb(1'h1, OFS_CONFIG, 32'h1);
    apb(1'h1, OFS_ENCODING, ENC_PREEMPT_TIMER);
    apb(1'h0, OFS_DECODE, 32'h0);
    chk(rd[13], 1'h1, "timer refused");
    apb(1'h1, OFS_CONFIG, 32'h0);
    $display("test decode done");
  endtask : t_decode
  task automatic t_entry();
    logic [31:0] e [6] = '{32'h4810, 32'h4812, 32'h4808, 32'h6806, 32'h680c, 32'h6810};
    logic [63:0] x [6] = '{64'hbeef, 64'hbeef, 64'hdead_beef, 64'h9abc_def0, 64'h9abc_def0, NAT};
    foreach (e[i]) fwrite(e[i], e[i][13] ? NAT : 64'hdead_beef);
    entry_event <= 1'h1;
    @(posedge pclk);
    entry_event <= 1'h0;
    @(posedge pclk);
    foreach (e[i]) begin
      fread(e[i]);
      chk(fv, x[i], "entry clearing");
    end
    fwrite(32'h6808, NAT);
    apb(1'h1, OFS_COMMAND, 32'h1 << CMD_ENTRY);
    fread(32'h6808);
    chk(fv, 64'h9abc_def0, "command entry");
    $display("test entry done");
  endtask : t_entry
  task automatic t_ro();
    fwrite(32'h6400, 64'h5);
    apb(1'h0, OFS_DECODE, 32'h0);
    chk(rd[20], 1'h1, "read-only write passed");
    fread(32'h6400);
    chk(fv, 64'h0, "read-only stored");
    apb(1'h1, OFS_COMMAND, 32'h1 << CMD_CLR_FAIL);
    apb(1'h0, OFS_DECODE, 32'h0);
    chk(rd[20], 1'h0, "fail not cleared");
    fwrite(32'h6800, 64'h11);
    fwrite(32'h6801, 64'h22);
    apb(1'h0, OFS_DECODE, 32'h0);
    chk(rd[20], 1'h1, "odd write passed");
    fread(32'h6800);
    chk(fv, 64'h11, "odd write stored");
    $display("test read-only done");
  endtask : t_ro
  task automatic t_ce();
    ce <= 1'h0;
    fork
      apb(1'h1, OFS_WDATA_LO, 32'ha5a5_0f0f);
      begin
        repeat (3) @(posedge pclk);
        chk(pready, 1'h0, "ready while stalled");
        ce <= 1'h1;
      end
    join
    apb(1'h0, OFS_WDATA_LO, 32'h0);
    chk(rd, 32'ha5a5_0f0f, "stalled write");
    $display("test stall done");
  endtask : t_ce
  task automatic t_rst2();
    fwrite(32'h4800, 64'h77);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    fread(32'h4800);
    chk(fv, 64'h0, "field after reset");
    $display("test reset done");
  endtask : t_rst2
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // ------------------------------------------------------------
  // main sequence and timeout
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs();
    t_decode();
    t_entry();
    t_ro();
    t_ce();
    t_rst2();
    complete_run();
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
endmodule : tb
bind vfd_top vfd_checker chk_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .entry_event(entry_event),
  .field_unsupported(field_unsupported));
`default_nettype wire
